// ---- ext_status_pkg.sv ----
// Constants and types for the extended status and drive strength register
`default_nettype none

package ext_status_pkg;

	// Serial opcodes
	localparam logic [7:0] OP_SET_NV   = 8'h85;
	localparam logic [7:0] OP_SET_VOL  = 8'h83;
	localparam logic [7:0] OP_READ_EXT = 8'h81;
	localparam logic [7:0] OP_CLEAR    = 8'h82;

	// Field positions of the extended register
	localparam int WIP_POS   = 0;
	localparam int PROT_POS  = 1;
	localparam int PROG_POS  = 2;
	localparam int ERASE_POS = 3;
	localparam int RSVD_POS  = 4;
	localparam int DS_LSB    = 5;
	localparam int DS_W      = 3;

	// Values after reset
	localparam logic [7:0]      EXT_RESET  = 8'hF0;
	localparam logic [DS_W-1:0] DS_DEFAULT = 3'h7;
	localparam logic            RSVD_VALUE = 1'h1;

	// Drive strength codes without a defined strength
	localparam logic [DS_W-1:0] DS_RSVD_A = 3'h0;
	localparam logic [DS_W-1:0] DS_RSVD_B = 3'h4;

	// Serial link framing
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Error flag set, ordered {erase, program, protection}
	localparam logic [2:0] ERR_NONE  = 3'h0;
	localparam logic [2:0] ERR_PROT  = 3'h1;
	localparam logic [2:0] ERR_PROG  = 3'h2;
	localparam logic [2:0] ERR_ERASE = 3'h4;

	// Kind of operation reported at its end by the command engine
	typedef enum logic [3:0] {
		OPK_NONE         = 4'h0,
		OPK_PAGE_PROG    = 4'h1,
		OPK_PROT_BIT_PRG = 4'h2,
		OPK_INFO_PROG    = 4'h3,
		OPK_MODE_PROG    = 4'h4,
		OPK_UNLOCK       = 4'h5,
		OPK_NV_REG       = 4'h6,
		OPK_STATUS_WRITE = 4'h7,
		OPK_FUNC_WRITE   = 4'h8,
		OPK_ERASE        = 4'h9,
		OPK_INFO_ERASE   = 4'hA,
		OPK_CHIP_ERASE   = 4'hB
	} op_kind_t;

	// Frame phases on the serial link
	typedef enum logic [1:0] {
		F_OPCODE = 2'h0,
		F_DATA   = 2'h1,
		F_READ   = 2'h3,
		F_DONE   = 2'h2
	} frame_state_t;

endpackage

`default_nettype wire

// ---- ext_status_reg.sv ----
// Extended status and drive strength register with its serial command front end
`default_nettype none

// Function
// - top three bits select output drive strength
// - drive codes decoded, 000 and 100 reserved
// - low four status bits untouched by writes
// - 85h writes non-volatile, 83h writes volatile copy
// - bit 0 mirrors the busy flag
// - protected array or locked row sets protection
// - program or register program failure sets program
// - erase or register erase failure sets erase
// - program to protected/suspended sets program+protection
// - locked row program sets program+protection
// - bad mode lock program sets program+protection
// - wrong password sets program+protection
// - register update erase/program steps set own flags
// - locked status write sets protection+erase
// - protected erase sets erase+protection
// - chip erase flags only block-protect coverage
// - one-way bits cleared silently, no error
// - read-only and frozen bits ignored, no error
// - error flags sticky until clear or reset
// - set error flags never block commands
// - bit 4 reserved one, defaults F0
module ext_status_reg (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          sck,
	input  wire logic                          cs_n,
	input  wire logic                          si,
	output var  logic                          so,
	output var  logic                          so_oe,
	input  wire logic                          busy,
	input  wire logic                          soft_reset,
	input  wire logic                          op_done,
	input  wire ext_status_pkg::op_kind_t      op_kind,
	input  wire logic                          op_fail,
	input  wire logic                          nv_erase_fail,
	input  wire logic                          nv_prog_fail,
	input  wire logic                          region_protected,
	input  wire logic                          region_suspended,
	input  wire logic                          info_row_locked,
	input  wire logic                          mode_already_chosen,
	input  wire logic [1:0]                    mode_lock_data,
	input  wire logic                          password_mismatch,
	input  wire logic                          status_write_disable_bit,
	input  wire logic                          wp_n,
	input  wire logic                          block_protect_hit,
	output var  logic [ext_status_pkg::DS_W-1:0] drive_strength,
	output var  logic [7:0]                    ext_status
);

	// Serial link domain
	ext_status_pkg::frame_state_t state_r;
	ext_status_pkg::frame_state_t state_nxt;
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic [7:0] rx_byte;
	logic       frame_rst;
	logic [7:0] cmd_r;
	logic [7:0] data_r;
	logic       req_tgl_r;
	logic       snap_req_s1_r;
	logic       snap_req_s2_r;
	logic       snap_ack_r;
	logic [7:0] snap_r;

	// System clock domain
	logic       req_s1_r;
	logic       req_s2_r;
	logic       req_s3_r;
	logic       ack_s1_r;
	logic       ack_s2_r;
	logic       wp_s1_r;
	logic       wp_s2_r;
	logic       cmd_pulse;
	logic       clear_err;
	logic [2:0] err_r;
	logic [2:0] err_set;
	logic       wip_r;
	logic [ext_status_pkg::DS_W-1:0] vol_ds_r;
	logic [ext_status_pkg::DS_W-1:0] nv_ds_r;
	logic [7:0] shadow_r;
	logic       snap_req_r;

	function automatic logic ds_valid(input logic [ext_status_pkg::DS_W-1:0] code);
		ds_valid = (code != ext_status_pkg::DS_RSVD_A) && (code != ext_status_pkg::DS_RSVD_B);
	endfunction

	// A frame ends or is aborted by its own select line, so sck may stop at any time
	assign frame_rst = cs_n | ~resetn;
	assign rx_byte   = {shift_r, si};

	always_comb begin
		state_nxt = state_r;
		if (bit_cnt_r == ext_status_pkg::LAST_BIT) begin
			case (state_r)
				ext_status_pkg::F_OPCODE: begin
					if (rx_byte == ext_status_pkg::OP_SET_NV ||
					    rx_byte == ext_status_pkg::OP_SET_VOL) begin
						state_nxt = ext_status_pkg::F_DATA;
					end else if (rx_byte == ext_status_pkg::OP_READ_EXT) begin
						state_nxt = ext_status_pkg::F_READ;
					end else begin
						state_nxt = ext_status_pkg::F_DONE;
					end
				end
				ext_status_pkg::F_DATA: state_nxt = ext_status_pkg::F_DONE;
				ext_status_pkg::F_READ: state_nxt = ext_status_pkg::F_READ;
				ext_status_pkg::F_DONE: state_nxt = ext_status_pkg::F_DONE;
				default:                state_nxt = ext_status_pkg::F_DONE;
			endcase
		end
	end

	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			state_r   <= ext_status_pkg::F_OPCODE;
			bit_cnt_r <= 3'h0;
			shift_r   <= 7'h00;
		end else begin
			state_r   <= state_nxt;
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r   <= rx_byte[6:0];
		end
	end

	// Command and data stay stable until the next frame; the toggle tells the clk side
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			cmd_r     <= 8'h00;
			data_r    <= 8'h00;
			req_tgl_r <= 1'b0;
		end else if (!cs_n && bit_cnt_r == ext_status_pkg::LAST_BIT) begin
			if (state_r == ext_status_pkg::F_OPCODE) begin
				cmd_r <= rx_byte;
				if (rx_byte == ext_status_pkg::OP_CLEAR) begin
					req_tgl_r <= ~req_tgl_r;
				end
			end else if (state_r == ext_status_pkg::F_DATA) begin
				data_r    <= rx_byte;
				req_tgl_r <= ~req_tgl_r;
			end
		end
	end

	// Register snapshot for reads; frozen during a read so a byte is never torn
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			snap_req_s1_r <= 1'b0;
			snap_req_s2_r <= 1'b0;
			snap_ack_r    <= 1'b0;
			snap_r        <= ext_status_pkg::EXT_RESET;
		end else begin
			snap_req_s1_r <= snap_req_r;
			snap_req_s2_r <= snap_req_s1_r;
			if (snap_req_s2_r != snap_ack_r && state_r != ext_status_pkg::F_READ) begin
				snap_r     <= shadow_r;
				snap_ack_r <= snap_req_s2_r;
			end
		end
	end

	// Read data leaves on the falling edge; the byte repeats while select stays low
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			so    <= 1'b0;
			so_oe <= 1'b0;
		end else if (state_r == ext_status_pkg::F_READ) begin
			so    <= snap_r[3'(ext_status_pkg::LAST_BIT - bit_cnt_r)];
			so_oe <= 1'b1;
		end else begin
			so    <= 1'b0;
			so_oe <= 1'b0;
		end
	end

	// Crossings into the system clock domain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_s3_r <= 1'b0;
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			wp_s1_r  <= 1'b1;
			wp_s2_r  <= 1'b1;
		end else begin
			req_s1_r <= req_tgl_r;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
			ack_s1_r <= snap_ack_r;
			ack_s2_r <= ack_s1_r;
			wp_s1_r  <= wp_n;
			wp_s2_r  <= wp_s1_r;
		end
	end

	assign cmd_pulse = req_s2_r ^ req_s3_r;
	assign clear_err = soft_reset | (cmd_pulse && cmd_r == ext_status_pkg::OP_CLEAR);

	// Error classification at the end of an operation
	always_comb begin
		err_set = ext_status_pkg::ERR_NONE;
		if (op_done) begin
			case (op_kind)
				ext_status_pkg::OPK_PAGE_PROG,
				ext_status_pkg::OPK_PROT_BIT_PRG: begin
					if (region_protected || region_suspended) begin
						err_set = ext_status_pkg::ERR_PROG | ext_status_pkg::ERR_PROT;
					end else if (op_fail) begin
						err_set = ext_status_pkg::ERR_PROG;
					end
				end
				ext_status_pkg::OPK_INFO_PROG: begin
					if (info_row_locked) begin
						err_set = ext_status_pkg::ERR_PROG | ext_status_pkg::ERR_PROT;
					end else if (op_fail) begin
						err_set = ext_status_pkg::ERR_PROG;
					end
				end
				ext_status_pkg::OPK_MODE_PROG: begin
					// Clearing the one-way location bit is filtered by the engine, no error
					if (mode_already_chosen || mode_lock_data == 2'h0) begin
						err_set = ext_status_pkg::ERR_PROG | ext_status_pkg::ERR_PROT;
					end else if (op_fail) begin
						err_set = ext_status_pkg::ERR_PROG;
					end
				end
				ext_status_pkg::OPK_UNLOCK: begin
					if (password_mismatch) begin
						err_set = ext_status_pkg::ERR_PROG | ext_status_pkg::ERR_PROT;
					end
				end
				ext_status_pkg::OPK_NV_REG: begin
					err_set = (nv_erase_fail ? ext_status_pkg::ERR_ERASE : ext_status_pkg::ERR_NONE)
					        | (nv_prog_fail ? ext_status_pkg::ERR_PROG : ext_status_pkg::ERR_NONE);
				end
				ext_status_pkg::OPK_STATUS_WRITE: begin
					if (status_write_disable_bit && !wp_s2_r) begin
						err_set = ext_status_pkg::ERR_PROT | ext_status_pkg::ERR_ERASE;
					end else begin
						err_set = (nv_erase_fail ? ext_status_pkg::ERR_ERASE : ext_status_pkg::ERR_NONE)
						        | (nv_prog_fail ? ext_status_pkg::ERR_PROG : ext_status_pkg::ERR_NONE);
					end
				end
				ext_status_pkg::OPK_FUNC_WRITE: begin
					if (op_fail) begin
						err_set = ext_status_pkg::ERR_PROG;
					end
				end
				ext_status_pkg::OPK_ERASE,
				ext_status_pkg::OPK_INFO_ERASE: begin
					if (region_protected || info_row_locked) begin
						err_set = ext_status_pkg::ERR_ERASE | ext_status_pkg::ERR_PROT;
					end else if (op_fail) begin
						err_set = ext_status_pkg::ERR_ERASE;
					end
				end
				ext_status_pkg::OPK_CHIP_ERASE: begin
					// Per-sector protection alone does not flag a chip erase
					if (block_protect_hit) begin
						err_set = ext_status_pkg::ERR_ERASE | ext_status_pkg::ERR_PROT;
					end else if (op_fail) begin
						err_set = ext_status_pkg::ERR_ERASE;
					end
				end
				default: err_set = ext_status_pkg::ERR_NONE;
			endcase
		end
	end

	// Sticky flags; a new error in the clearing cycle survives the clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			err_r <= ext_status_pkg::ERR_NONE;
		end else begin
			err_r <= (clear_err ? ext_status_pkg::ERR_NONE : err_r) | err_set;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wip_r <= 1'b0;
		end else begin
			wip_r <= busy;
		end
	end

	// Drive strength copies; only the top field of a written byte is taken
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nv_ds_r <= ext_status_pkg::DS_DEFAULT;
		end else if (cmd_pulse && cmd_r == ext_status_pkg::OP_SET_NV) begin
			nv_ds_r <= data_r[ext_status_pkg::DS_LSB +: ext_status_pkg::DS_W];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vol_ds_r <= ext_status_pkg::DS_DEFAULT;
		end else if (soft_reset) begin
			vol_ds_r <= nv_ds_r;
		end else if (cmd_pulse && (cmd_r == ext_status_pkg::OP_SET_VOL ||
		                           cmd_r == ext_status_pkg::OP_SET_NV)) begin
			vol_ds_r <= data_r[ext_status_pkg::DS_LSB +: ext_status_pkg::DS_W];
		end
	end

	// Reserved codes are stored but the drivers keep their last defined strength
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive_strength <= ext_status_pkg::DS_DEFAULT;
		end else if (ds_valid(vol_ds_r)) begin
			drive_strength <= vol_ds_r;
		end
	end

	// Status bits come only from hardware; written data never reaches them
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ext_status <= ext_status_pkg::EXT_RESET;
		end else begin
			ext_status[ext_status_pkg::DS_LSB +: ext_status_pkg::DS_W] <= vol_ds_r;
			ext_status[ext_status_pkg::RSVD_POS]  <= ext_status_pkg::RSVD_VALUE;
			ext_status[ext_status_pkg::ERASE_POS] <= err_r[2];
			ext_status[ext_status_pkg::PROG_POS]  <= err_r[1];
			ext_status[ext_status_pkg::PROT_POS]  <= err_r[0];
			ext_status[ext_status_pkg::WIP_POS]   <= wip_r;
		end
	end

	// Hands the register value to the link side; no command path waits on errors
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shadow_r   <= ext_status_pkg::EXT_RESET;
			snap_req_r <= 1'b0;
		end else if (ack_s2_r == snap_req_r && shadow_r != ext_status) begin
			shadow_r   <= ext_status;
			snap_req_r <= ~snap_req_r;
		end
	end

endmodule

`default_nettype wire

// ---- ext_status_monitor.sv ----
// Port checker for the extended status register
`default_nettype none
module ext_status_monitor (
	input wire logic                     clk,
	input wire logic                     resetn,
	input wire logic                     cs_n,
	input wire logic                     so_oe,
	input wire logic                     busy,
	input wire logic                     soft_reset,
	input wire logic                     op_done,
	input wire ext_status_pkg::op_kind_t op_kind,
	input wire logic                     region_protected,
	input wire logic                     block_protect_hit,
	input wire logic [2:0]               drive_strength,
	input wire logic [7:0]               ext_status
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_wip_mirror: assert property (ext_status[0] == $past(busy, 2))
		else $error("wip bit does not follow busy");
	// Select high resets the output stage at once, so no sample may see it driving
	a_oe_idle: assert property (cs_n |-> !so_oe)
		else $error("data output enabled outside a frame");
	a_rsvd_one: assert property (ext_status[4])
		else $error("reserved bit not one");
	a_drive_legal: assert property (drive_strength != 3'h0 && drive_strength != 3'h4)
		else $error("drive strength holds a reserved code");
	// Clears arrive only through the link or soft reset, so a quiet window pins them
	a_err_sticky: assert property ((cs_n && !soft_reset)[*6] |=>
		($past(ext_status[3:1]) & ~ext_status[3:1]) == 3'h0)
		else $error("error flag dropped without a clear");
	a_drive_hold: assert property ((cs_n && !soft_reset)[*6] |=> $stable(ext_status[7:5]))
		else $error("drive field moved without a write");
	a_prog_prot: assert property (op_done && op_kind == ext_status_pkg::OPK_PAGE_PROG
		&& region_protected |-> ##3 ext_status[2:1] == 2'h3)
		else $error("protected program did not flag");
	a_erase_prot: assert property (op_done && op_kind == ext_status_pkg::OPK_ERASE
		&& region_protected |-> ##3 ext_status[3] && ext_status[1])
		else $error("protected erase did not flag");
	a_chip_block: assert property (op_done && op_kind == ext_status_pkg::OPK_CHIP_ERASE
		&& block_protect_hit |-> ##3 ext_status[3] && ext_status[1])
		else $error("chip erase over protected block did not flag");
	c_event: cover property (op_done);
	c_busy: cover property ($rose(busy));
	c_frame: cover property ($fell(cs_n));
endmodule
bind ext_status_reg ext_status_monitor u_mon (.clk, .resetn, .cs_n, .so_oe, .busy, .soft_reset,
	.op_done, .op_kind, .region_protected, .block_protect_hit, .drive_strength, .ext_status);
`default_nettype wire

// ---- flash_host_model.sv ----
// Host controller model that frames commands on the serial link
`default_nettype none
module flash_host_model (
	output var logic sck,
	output var logic cs_n,
	output var logic si,
	input wire logic so
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Clock idles low between frames; data moves on the falling edge
	task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int n,
			output logic [7:0] rd);
		logic [15:0] sh;
		sh = {op, dat};
		rd = 8'h00;
		#3 cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = sh[15 - i];
			#7.5 sck = 1'b1;
			if (i > 7)
				rd = {rd[6:0], so};
			#7.5 sck = 1'b0;
		end
		#5 cs_n = 1'b1;
		si = ~si;
	endtask
endmodule
`default_nettype wire

// ---- flash_ext_status_error_register_tb_top.sv ----
// Self-checking bench for the extended status register
`default_nettype none
module flash_ext_status_error_register_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, resetn, busy, soft_reset, op_done, sck, cs_n, si, so, so_oe;
	logic [3:0]  kind;
	logic [12:0] qv;
	logic [2:0]  drive_strength;
	logic [7:0]  ext_status, rd;
	int          checks, miscompares, cyc;
	ext_status_reg DUT (.clk, .resetn, .sck, .cs_n, .si, .so, .so_oe, .busy, .soft_reset,
		.op_done, .op_kind(ext_status_pkg::op_kind_t'(kind)), .op_fail(qv[11]),
		.nv_erase_fail(qv[10]), .nv_prog_fail(qv[9]), .region_protected(qv[8]),
		.region_suspended(qv[7]), .info_row_locked(qv[6]), .mode_already_chosen(qv[5]),
		.mode_lock_data(qv[4:3]), .password_mismatch(qv[2]),
		.status_write_disable_bit(qv[1]), .wp_n(qv[12]), .block_protect_hit(qv[0]),
		.drive_strength, .ext_status);
	flash_host_model host (.sck, .cs_n, .si, .so);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic pulse_soft();
		@(posedge clk);
		soft_reset <= 1'b1;
		@(posedge clk);
		soft_reset <= 1'b0;
	endtask
	// Qualifiers settle four cycles ahead so the write-protect pin clears its synchroniser
	task automatic ev(input logic [3:0] k, input logic [12:0] q, input logic [2:0] e,
			input logic keep);
		if (!keep)
			pulse_soft();
		@(posedge clk);
		kind <= k;
		qv <= q;
		repeat (4) @(posedge clk);
		op_done <= 1'b1;
		@(posedge clk);
		op_done <= 1'b0;
		kind <= 4'h0;
		qv <= 13'h1000;
		repeat (4) @(posedge clk);
		chk("error flags", {5'h00, e}, {5'h00, ext_status[3:1]});
	endtask
	task automatic t_events();
		ev(4'h1, 13'h1100, 3'h3, 1'b0);
		ev(4'h2, 13'h1080, 3'h3, 1'b0);
		ev(4'h1, 13'h1800, 3'h2, 1'b0);
		ev(4'h3, 13'h1040, 3'h3, 1'b0);
		ev(4'h3, 13'h1800, 3'h2, 1'b0);
		ev(4'h4, 13'h1038, 3'h3, 1'b0);
		ev(4'h4, 13'h1000, 3'h3, 1'b0);
		ev(4'h4, 13'h1008, 3'h0, 1'b0);
		ev(4'h5, 13'h1004, 3'h3, 1'b0);
		ev(4'h6, 13'h1400, 3'h4, 1'b0);
		ev(4'h7, 13'h0002, 3'h5, 1'b0);
		ev(4'h7, 13'h1002, 3'h0, 1'b0);
		ev(4'h8, 13'h1800, 3'h2, 1'b0);
		ev(4'h8, 13'h1000, 3'h0, 1'b0);
		ev(4'hA, 13'h1040, 3'h5, 1'b0);
		ev(4'h9, 13'h1100, 3'h5, 1'b0);
		ev(4'hB, 13'h1100, 3'h0, 1'b0);
		ev(4'h9, 13'h1800, 3'h4, 1'b0);
		ev(4'h1, 13'h1800, 3'h6, 1'b1);
		ev(4'h5, 13'h1000, 3'h6, 1'b1);
		$display("events done");
	endtask
	task automatic t_write();
		ev(4'hB, 13'h1001, 3'h5, 1'b0);
		host.frame(8'h83, 8'h3F, 16, rd);
		repeat (8) @(posedge clk);
		chk("ext_status", 8'h3A, ext_status);
		chk("drive", 8'h01, {5'h00, drive_strength});
		host.frame(8'h85, 8'hDF, 16, rd);
		repeat (8) @(posedge clk);
		chk("ext_status", 8'hDA, ext_status);
		host.frame(8'h83, 8'h00, 16, rd);
		host.frame(8'h05, 8'hE0, 16, rd);
		host.frame(8'h85, 8'h20, 12, rd);
		repeat (8) @(posedge clk);
		chk("ext_status", 8'h1A, ext_status);
		chk("drive", 8'h06, {5'h00, drive_strength});
		pulse_soft();
		repeat (4) @(posedge clk);
		chk("ext_status", 8'hD0, ext_status);
		$display("write done");
	endtask
	task automatic t_busy();
		@(posedge clk);
		busy <= 1'b1;
		repeat (3) @(posedge clk);
		chk("wip", 8'hD1, ext_status);
		busy <= 1'b0;
		repeat (3) @(posedge clk);
		chk("wip", 8'hD0, ext_status);
		$display("busy done");
	endtask
	task automatic t_read_clear();
		// First read may return a stale snapshot
		host.frame(8'h81, 8'h00, 16, rd);
		host.frame(8'h81, 8'h00, 16, rd);
		chk("read byte", 8'hD0, rd);
		ev(4'h6, 13'h1200, 3'h2, 1'b1);
		host.frame(8'h82, 8'h00, 8, rd);
		repeat (8) @(posedge clk);
		chk("ext_status", 8'hD0, ext_status);
		$display("read and clear done");
	endtask
	task automatic t_hw_reset();
		ev(4'h9, 13'h1800, 3'h4, 1'b1);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		chk("ext_status", 8'hF0, ext_status);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		chk("drive", 8'h07, {5'h00, drive_strength});
		$display("reset done");
	endtask
	initial begin
		checks = 0;
		miscompares = 0;
		resetn = 1'b0;
		busy = 1'b0;
		soft_reset = 1'b0;
		op_done = 1'b0;
		kind = 4'h0;
		qv = 13'h1000;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		chk("ext_status", 8'hF0, ext_status);
		chk("drive", 8'h07, {5'h00, drive_strength});
		t_events();
		t_write();
		t_busy();
		t_read_clear();
		t_hw_reset();
		conclude();
	end
endmodule
`default_nettype wire
